// ===== shared/dual_target_pkg.sv
// constants and carrier types for the dual-target serial slave
`default_nettype none
package dual_target_pkg;
  localparam int unsigned EE_AW       = 15;
  localparam logic [5:0]  MP_FIXED    = 6'h10;
  localparam logic [5:0]  EE_FIXED    = 6'h28;
  localparam logic [2:0]  EXT_ALL     = 3'h6;
  localparam logic [5:0]  PAGE_LAST   = 6'h3f;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  LAST_BIT    = 4'h7;
  localparam logic [1:0]  IDX_EE_DATA = 2'h2;
  localparam logic [1:0]  IDX_MAX     = 2'h3;
  localparam logic [7:0]  FILL_BYTE   = 8'hff;
  localparam logic [14:0] EE_LAST_DEF = 15'h07ff;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_RX     = 8'h02,
    ST_DECIDE = 8'h04,
    ST_RXACK  = 8'h08,
    ST_STALL  = 8'h10,
    ST_FETCH  = 8'h20,
    ST_TX     = 8'h40,
    ST_TXACK  = 8'h80
  } state_e;

  typedef struct packed {
    logic              is_eeprom;
    logic [EE_AW-1:0]  addr;
    logic [7:0]        data;
  } wr_word_s;

  typedef struct packed {
    logic              is_eeprom;
    logic [EE_AW-1:0]  addr;
  } rd_req_s;
endpackage : dual_target_pkg
`default_nettype wire

// ===== logic/i2c_dual_target_access.sv
// serial slave front end: register block and eeprom targets
// Function
// - default addresses 010000A0 and 101000A0
// - each used extra line replaces fixed bit
// - full extension: msb 0 byte is pointer
// - full extension: msb 1 starts masked address
// - eeprom access carries high then low address
// - read advances address, stops one past end
// - read start or write byte past eeprom end is refused; read bytes past it are ff
// - page crossing stretches clock until programmed
// - register writes start with pointer byte
// - high reset input holds bus logic idle; pointer and address are kept
// - write block input refuses eeprom writes
// - shared pins serve address or write block
`default_nettype none
module i2c_dual_target_access #(
  parameter logic [14:0] EE_LAST = dual_target_pkg::EE_LAST_DEF
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic                      i_pin_reset_in,
  input  wire logic                      i_scl,
  output logic                           o_scl,
  output logic                           o_scl_oe_n,
  input  wire logic                      i_sda,
  output logic                           o_sda,
  output logic                           o_sda_oe_n,
  input  wire logic                      i_addr_select_bit0,
  input  wire logic [5:0]                i_addr_select_ext_lines,
  input  wire logic [2:0]                i_ext_line_count,
  input  wire logic                      i_wd_enable,
  input  wire logic                      i_eeprom_write_block_in,
  output logic                           o_wr_valid,
  output dual_target_pkg::wr_word_s      o_wr_word,
  input  wire logic                      i_wr_ready,
  output logic                           o_ee_commit,
  input  wire logic                      i_ee_busy,
  output logic                           o_rd_req,
  output dual_target_pkg::rd_req_s       o_rd_word,
  input  wire logic                      i_rd_valid,
  input  wire logic [7:0]                i_rd_data
);
  dual_target_pkg::state_e    state_q, state_d;
  logic [3:0]                 cnt_q, cnt_d;
  logic [7:0]                 sh_q, sh_d;
  logic [1:0]                 idx_q, idx_d;
  logic [1:0]                 ph_q, ph_d;
  logic [14:0]                addr_q, addr_d;
  logic [7:0]                 ptr_q, ptr_d;
  logic                       addr_ph_q, addr_ph_d;
  logic                       rw_q, rw_d;
  logic                       tgt_ee_q, tgt_ee_d;
  logic                       ack_q, ack_d;
  logic                       pend_q, pend_d;
  logic                       dirty_q, dirty_d;
  logic                       scl_prev_q, sda_prev_q;
  logic                       sda_oe_n_q, sda_oe_n_d;
  logic                       scl_oe_n_q, scl_oe_n_d;
  logic                       commit_q, commit_d;
  logic                       rd_req_q, rd_req_d;
  dual_target_pkg::rd_req_s   rd_word_q, rd_word_d;
  dual_target_pkg::wr_word_s  head_q, head_d, skid_q, skid_d, push_word;
  logic                       head_v_q, head_v_d, skid_v_q, skid_v_d;
  logic                       push, buf_ready, buf_empty;
  logic                       pin_low_q;
  logic [5:0]                 ext_mask;
  logic [6:0]                 mp_exp, ee_exp;
  logic                       hit_mp, hit_ee, full_ext, past_end;
  logic                       scl_rise, scl_fall, start, stop;
  logic                       wd_block, mp_first;

  // each enabled line takes over the next fixed bit upward
  for (genvar g = 0; g < 6; g++)
  begin : g_mask
    assign ext_mask[g] = (i_ext_line_count > 3'(g));
  end

  assign mp_exp = {(dual_target_pkg::MP_FIXED & ~ext_mask) |
                   (i_addr_select_ext_lines & ext_mask),
                   i_addr_select_bit0};
  assign ee_exp = {(dual_target_pkg::EE_FIXED & ~ext_mask) |
                   (i_addr_select_ext_lines & ext_mask),
                   i_addr_select_bit0};
  assign hit_mp   = (sh_q[7:1] == mp_exp);
  assign hit_ee   = (sh_q[7:1] == ee_exp);
  assign full_ext = (i_ext_line_count >= dual_target_pkg::EXT_ALL);
  assign past_end = (addr_q > EE_LAST);
  assign wd_block = i_wd_enable && i_eeprom_write_block_in;
  assign mp_first = full_ext ? !sh_q[7] : !tgt_ee_q;
  assign scl_rise = i_scl && !scl_prev_q;
  assign scl_fall = !i_scl && scl_prev_q;
  assign start    = i_scl && scl_prev_q && sda_prev_q && !i_sda;
  assign stop     = i_scl && scl_prev_q && !sda_prev_q && i_sda;
  assign buf_ready = !skid_v_q;
  assign buf_empty = !head_v_q && !skid_v_q;

  // two-entry buffer; the sink may stall, the front end then stretches
  always_comb
  begin
    head_d   = head_q;
    head_v_d = head_v_q;
    skid_d   = skid_q;
    skid_v_d = skid_v_q;
    if (head_v_q && i_wr_ready)
    begin
      head_d   = skid_q;
      head_v_d = skid_v_q;
      skid_v_d = 1'b0;
    end
    if (push)
    begin
      if (!head_v_d)
      begin
        head_d   = push_word;
        head_v_d = 1'b1;
      end
      else
      begin
        skid_d   = push_word;
        skid_v_d = 1'b1;
      end
    end
    if (i_pin_reset_in)
    begin
      head_v_d = 1'b0;
      skid_v_d = 1'b0;
    end
  end

  always_comb
  begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    idx_d      = idx_q;
    ph_d       = ph_q;
    addr_d     = addr_q;
    ptr_d      = ptr_q;
    addr_ph_d  = addr_ph_q;
    rw_d       = rw_q;
    tgt_ee_d   = tgt_ee_q;
    ack_d      = ack_q;
    pend_d     = pend_q;
    dirty_d    = dirty_q;
    sda_oe_n_d = sda_oe_n_q;
    commit_d   = 1'b0;
    rd_req_d   = 1'b0;
    rd_word_d  = rd_word_q;
    push       = 1'b0;
    push_word  = '0;
    case (state_q)
      dual_target_pkg::ST_RX:
      begin
        if (scl_rise)
        begin
          sh_d  = {sh_q[6:0], i_sda};
          cnt_d = cnt_q + 4'h1;
        end
        else if (scl_fall && cnt_q == dual_target_pkg::BYTE_BITS)
          state_d = dual_target_pkg::ST_DECIDE;
      end
      dual_target_pkg::ST_DECIDE:
      begin
        state_d = dual_target_pkg::ST_RXACK;
        ack_d   = 1'b1;
        if (addr_ph_q)
        begin
          rw_d = sh_q[0];
          if (!(hit_mp || hit_ee))
            ack_d = 1'b0;
          else if (!full_ext)
            tgt_ee_d = hit_ee;
          // with all extra lines used, a read lands on the target chosen by the last write; otherwise on the addressed one
          if (sh_q[0] && (full_ext ? tgt_ee_q : hit_ee) && past_end)
            ack_d = 1'b0;
        end
        else if (idx_q == 2'h0 && mp_first)
        begin
          ptr_d    = sh_q;
          tgt_ee_d = 1'b0;
        end
        else if (idx_q == 2'h0)
        begin
          addr_d[14:8] = sh_q[6:0];
          tgt_ee_d     = 1'b1;
        end
        else if (tgt_ee_q && idx_q == 2'h1)
          addr_d[7:0] = sh_q;
        else if (!buf_ready)
          state_d = dual_target_pkg::ST_DECIDE;
        else if (tgt_ee_q && (past_end || wd_block))
          ack_d = 1'b0;
        else
        begin
          push      = 1'b1;
          push_word = {tgt_ee_q, tgt_ee_q ? addr_q : {7'h00, ptr_q}, sh_q};
          if (tgt_ee_q)
          begin
            addr_d  = addr_q + 15'h0001;
            dirty_d = 1'b1;
            if (addr_q[5:0] == dual_target_pkg::PAGE_LAST)
              pend_d = 1'b1;
          end
        end
        if (state_d == dual_target_pkg::ST_RXACK)
        begin
          sda_oe_n_d = !ack_d;
          addr_ph_d  = 1'b0;
          if (!addr_ph_q && idx_q != dual_target_pkg::IDX_MAX)
            idx_d = idx_q + 2'h1;
        end
      end
      dual_target_pkg::ST_RXACK:
      begin
        if (scl_fall)
        begin
          sda_oe_n_d = 1'b1;
          cnt_d      = 4'h0;
          if (!ack_q)
            state_d = dual_target_pkg::ST_IDLE;
          else if (pend_q)
            state_d = dual_target_pkg::ST_STALL;
          else if (rw_q)
            state_d = dual_target_pkg::ST_FETCH;
          else
            state_d = dual_target_pkg::ST_RX;
        end
      end
      dual_target_pkg::ST_STALL:
      begin
        // drain the buffer, start programming, wait out busy
        if (ph_q == 2'h0 && buf_empty)
        begin
          commit_d = 1'b1;
          ph_d     = 2'h1;
        end
        else if (ph_q == 2'h1)
          ph_d = 2'h2;
        else if (ph_q == 2'h2 && !i_ee_busy)
        begin
          ph_d    = 2'h0;
          pend_d  = 1'b0;
          dirty_d = 1'b0;
          state_d = dual_target_pkg::ST_RX;
        end
      end
      dual_target_pkg::ST_FETCH:
      begin
        if (ph_q == 2'h0 && tgt_ee_q && past_end)
        begin
          sh_d       = dual_target_pkg::FILL_BYTE;
          sda_oe_n_d = dual_target_pkg::FILL_BYTE[7];
          state_d    = dual_target_pkg::ST_TX;
        end
        else if (ph_q == 2'h0)
        begin
          rd_req_d  = 1'b1;
          rd_word_d = {tgt_ee_q, tgt_ee_q ? addr_q : {7'h00, ptr_q}};
          ph_d      = 2'h1;
        end
        else if (i_rd_valid)
        begin
          ph_d       = 2'h0;
          sh_d       = i_rd_data;
          sda_oe_n_d = i_rd_data[7];
          state_d    = dual_target_pkg::ST_TX;
          if (tgt_ee_q && !past_end)
            addr_d = addr_q + 15'h0001;
        end
      end
      dual_target_pkg::ST_TX:
      begin
        if (scl_fall && cnt_q == dual_target_pkg::LAST_BIT)
        begin
          sda_oe_n_d = 1'b1;
          state_d    = dual_target_pkg::ST_TXACK;
        end
        else if (scl_fall)
        begin
          cnt_d      = cnt_q + 4'h1;
          sh_d       = {sh_q[6:0], 1'b0};
          sda_oe_n_d = sh_q[6];
        end
      end
      dual_target_pkg::ST_TXACK:
      begin
        if (scl_rise)
          ack_d = !i_sda;
        else if (scl_fall)
        begin
          cnt_d   = 4'h0;
          state_d = ack_q ? dual_target_pkg::ST_FETCH
                          : dual_target_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_d = dual_target_pkg::ST_IDLE;
      end
    endcase
    if (stop)
    begin
      state_d    = dual_target_pkg::ST_IDLE;
      sda_oe_n_d = 1'b1;
      // partial page is programmed once the master lets go
      if (dirty_q && !pend_q)
      begin
        commit_d = 1'b1;
        dirty_d  = 1'b0;
      end
    end
    if (start)
    begin
      state_d    = dual_target_pkg::ST_RX;
      cnt_d      = 4'h0;
      idx_d      = 2'h0;
      addr_ph_d  = 1'b1;
      sda_oe_n_d = 1'b1;
    end
    if (i_pin_reset_in)
    begin
      state_d    = dual_target_pkg::ST_IDLE;
      sda_oe_n_d = 1'b1;
      commit_d   = 1'b0;
      rd_req_d   = 1'b0;
      pend_d     = 1'b0;
      dirty_d    = 1'b0;
      ph_d       = 2'h0;
    end
    // clock held low in exactly these states
    scl_oe_n_d = !(state_d == dual_target_pkg::ST_DECIDE ||
                   state_d == dual_target_pkg::ST_STALL ||
                   state_d == dual_target_pkg::ST_FETCH);
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q    <= dual_target_pkg::ST_IDLE;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      idx_q      <= 2'h0;
      ph_q       <= 2'h0;
      addr_q     <= 15'h0000;
      ptr_q      <= 8'h00;
      addr_ph_q  <= 1'b0;
      rw_q       <= 1'b0;
      tgt_ee_q   <= 1'b0;
      ack_q      <= 1'b0;
      pend_q     <= 1'b0;
      dirty_q    <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      commit_q   <= 1'b0;
      rd_req_q   <= 1'b0;
      rd_word_q  <= '0;
      head_q     <= '0;
      head_v_q   <= 1'b0;
      skid_q     <= '0;
      skid_v_q   <= 1'b0;
      pin_low_q  <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      idx_q      <= idx_d;
      ph_q       <= ph_d;
      addr_q     <= addr_d;
      ptr_q      <= ptr_d;
      addr_ph_q  <= addr_ph_d;
      rw_q       <= rw_d;
      tgt_ee_q   <= tgt_ee_d;
      ack_q      <= ack_d;
      pend_q     <= pend_d;
      dirty_q    <= dirty_d;
      scl_prev_q <= i_scl;
      sda_prev_q <= i_sda;
      sda_oe_n_q <= sda_oe_n_d;
      scl_oe_n_q <= scl_oe_n_d;
      commit_q   <= commit_d;
      rd_req_q   <= rd_req_d;
      rd_word_q  <= rd_word_d;
      head_q     <= head_d;
      head_v_q   <= head_v_d;
      skid_q     <= skid_d;
      skid_v_q   <= skid_v_d;
      pin_low_q  <= 1'b0;
    end
  end

  assign o_scl      = pin_low_q;
  assign o_sda      = pin_low_q;
  assign o_scl_oe_n = scl_oe_n_q;
  assign o_sda_oe_n = sda_oe_n_q;
  assign o_wr_valid = head_v_q;
  assign o_wr_word  = head_q;
  assign o_ee_commit = commit_q;
  assign o_rd_req   = rd_req_q;
  assign o_rd_word  = rd_word_q;

  logic dec_a, dec_d, ee_dat;
  assign dec_a  = state_q == dual_target_pkg::ST_DECIDE && addr_ph_q;
  assign dec_d  = state_q == dual_target_pkg::ST_DECIDE && !addr_ph_q;
  assign ee_dat = dec_d && tgt_ee_q && idx_q >= dual_target_pkg::IDX_EE_DATA
                  && buf_ready && !i_pin_reset_in;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn || i_pin_reset_in);

  addr_default_a: assert property (
    dec_a && i_ext_line_count == 3'h0 && !stop && !start &&
    sh_q[7:1] == {dual_target_pkg::MP_FIXED, i_addr_select_bit0}
    |=> !o_sda_oe_n ##1 !o_sda_oe_n || state_q != dual_target_pkg::ST_RXACK)
    else $error("default register address not acknowledged");
  ext_line_a: assert property (
    dec_a && i_ext_line_count == 3'h1 && !stop && !start &&
    sh_q[7:1] == {dual_target_pkg::MP_FIXED[5:1],
                  i_addr_select_ext_lines[0], i_addr_select_bit0}
    |=> !o_sda_oe_n && state_q == dual_target_pkg::ST_RXACK)
    else $error("extended address not acknowledged");
  ptr_pick_a: assert property (
    dec_d && full_ext && idx_q == 2'h0 && !sh_q[7] && !start
    |=> ptr_q == $past(sh_q) && !tgt_ee_q)
    else $error("pointer byte not taken");
  ee_mask_a: assert property (
    dec_d && full_ext && idx_q == 2'h0 && sh_q[7] && !start
    |=> addr_q[14:8] == $past(sh_q[6:0]) && tgt_ee_q)
    else $error("masked eeprom high byte wrong");
  low_byte_a: assert property (
    dec_d && tgt_ee_q && idx_q == 2'h1 && !start
    |=> addr_q[7:0] == $past(sh_q) && addr_q[14:8] == $past(addr_q[14:8]))
    else $error("eeprom low byte wrong");
  rd_advance_a: assert property (
    state_q == dual_target_pkg::ST_FETCH && ph_q == 2'h1 && i_rd_valid &&
    tgt_ee_q && !past_end && !start && !stop
    |=> addr_q == $past(addr_q) + 15'h0001)
    else $error("read address not advanced");
  nack_end_a: assert property (
    ee_dat && past_end && !start && !stop |=> o_sda_oe_n [*2])
    else $error("access past end acknowledged");
  page_hold_a: assert property (
    state_q == dual_target_pkg::ST_RXACK && scl_fall && ack_q && pend_q &&
    !start && !stop |=> !o_scl_oe_n ##1 !o_scl_oe_n)
    else $error("page crossing not stretched");
  pin_reset_a: assert property (
    @(posedge i_clock) disable iff (!i_rstn)
    i_pin_reset_in |=> state_q == dual_target_pkg::ST_IDLE && o_sda_oe_n
                       && o_scl_oe_n && !o_ee_commit)
    else $error("pin reset ignored");
  wd_refuse_a: assert property (
    ee_dat && wd_block && !start && !stop |=> o_sda_oe_n)
    else $error("blocked write acknowledged");
  no_match_a: assert property (
    dec_a && !hit_mp && !hit_ee && !start && !stop |=> o_sda_oe_n)
    else $error("foreign address acknowledged");
  mp_push_a: assert property (
    dec_d && !tgt_ee_q && idx_q != 2'h0 && buf_ready && !start
    |=> o_wr_valid)
    else $error("register write lost");

  ee_read_c: cover property (rd_req_q && rd_word_q.is_eeprom);
  page_c:    cover property (commit_q && state_q == dual_target_pkg::ST_STALL);
  mp_wr_c:   cover property (o_wr_valid && !o_wr_word.is_eeprom);
  full_c:    cover property (skid_v_q && !i_wr_ready);
endmodule : i2c_dual_target_access
`default_nettype wire

// ===== sim/serial_bus_master.sv
// two-wire bus master model that honours clock stretching
`default_nettype none
module serial_bus_master #(
  parameter int QTR = 4
) (
  input  wire logic i_clock,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;

  int stuck = 0;

  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic wait_q(input int n);
    repeat (n) @(posedge i_clock);
  endtask : wait_q

  // bounded wait: a device that never lets go is reported, not hung on
  task automatic scl_high();
    int k;
    k = 0;
    @(posedge i_clock);
    o_scl <= 1'b1;
    while (i_scl !== 1'b1 && k < 4000)
    begin
      @(posedge i_clock);
      k++;
    end
    if (k >= 4000)
      stuck++;
    wait_q(QTR);
  endtask : scl_high

  task automatic scl_low();
    @(posedge i_clock);
    o_scl <= 1'b0;
    wait_q(QTR);
  endtask : scl_low

  task automatic set_sda(input logic v);
    @(posedge i_clock);
    o_sda <= v;
    wait_q(QTR);
  endtask : set_sda

  // plain or repeated start
  task automatic start();
    set_sda(1'b1);
    scl_high();
    set_sda(1'b0);
    scl_low();
  endtask : start

  task automatic stop();
    set_sda(1'b0);
    scl_high();
    set_sda(1'b1);
  endtask : stop

  task automatic bit_io(input logic v, output logic s);
    set_sda(v);
    scl_high();
    s = i_sda;
    scl_low();
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask : rd_byte
endmodule : serial_bus_master
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the dual-target serial slave
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [14:0] EE_END = 15'h01ff;
  localparam int          BUSY   = 40;

  logic clk, rstn, pin_rst, m_scl, m_sda, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic a0, wd_en, wblk, wr_valid, wr_ready, commit, ee_busy, rd_req;
  logic rd_valid, hold, ack;
  logic [5:0] ext;
  logic [2:0] ext_n;
  logic [7:0] rd_data, rb;
  logic [6:0] mad, ead;
  dual_target_pkg::wr_word_s wr_word;
  dual_target_pkg::rd_req_s  rd_word;
  dual_target_pkg::wr_word_s wq[$];
  dual_target_pkg::rd_req_s  rq[$];
  int err_count, samples_checked, commits, c0, run, mx, busy_cnt, rd_cnt;
  integer seed = 32'h96b5d496;

  wire scl_w = m_scl & (scl_oe_n | scl_o);
  wire sda_w = m_sda & (sda_oe_n | sda_o);
  assign ee_busy = busy_cnt != 0;

  i2c_dual_target_access #(.EE_LAST(EE_END)) dut (
    .i_clock(clk), .i_rstn(rstn), .i_pin_reset_in(pin_rst),
    .i_scl(scl_w), .o_scl(scl_o), .o_scl_oe_n(scl_oe_n),
    .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n),
    .i_addr_select_bit0(a0), .i_addr_select_ext_lines(ext),
    .i_ext_line_count(ext_n), .i_wd_enable(wd_en),
    .i_eeprom_write_block_in(wblk), .o_wr_valid(wr_valid),
    .o_wr_word(wr_word), .i_wr_ready(wr_ready), .o_ee_commit(commit),
    .i_ee_busy(ee_busy), .o_rd_req(rd_req), .o_rd_word(rd_word),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data));

  serial_bus_master #(.QTR(4)) master (
    .i_clock(clk), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl(m_scl), .o_sda(m_sda));

  always #2.5 clk = ~clk;

  task automatic chk(input string what, input logic [23:0] e,
                     input logic [23:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (master.stuck != 0)
      err_count++;
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  function automatic logic [6:0] dev(input logic [5:0] fix,
                                     input logic [2:0] n);
    logic [5:0] m;
    m = ~(6'h3f << n);
    return {(fix & ~m) | (ext & m), a0};
  endfunction : dev

  function automatic logic [7:0] pat(input logic [14:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : pat

  task automatic open_tx(input logic [6:0] ad, input logic rw,
                         input logic ok);
    master.start();
    master.wr_byte({ad, rw}, ack);
    chk("addr_ack", 24'(ok), 24'(ack));
  endtask : open_tx

  task automatic put(input logic [7:0] b, input logic ok);
    master.wr_byte(b, ack);
    chk("data_ack", 24'(ok), 24'(ack));
  endtask : put

  task automatic mp_write(input logic [6:0] ad, input int nb);
    logic [7:0] p, d;
    p = 8'($random(seed)) & 8'h7f;
    open_tx(ad, 1'b0, 1'b1);
    put(p, 1'b1);
    for (int i = 0; i < nb; i++)
    begin
      d = 8'($random(seed));
      wq.push_back({1'b0, 7'h00, p, d});
      put(d, 1'b1);
    end
    master.stop();
  endtask : mp_write

  task automatic ee_wr(input logic [6:0] ad, input logic [14:0] a,
                       input int nb);
    logic [7:0] d;
    logic ok;
    open_tx(ad, 1'b0, 1'b1);
    put({1'b1, a[14:8]}, 1'b1);
    put(a[7:0], 1'b1);
    for (int i = 0; i < nb; i++)
    begin
      d = 8'($random(seed));
      ok = (a + i <= EE_END) && !(wd_en && wblk);
      if (ok)
        wq.push_back({1'b1, 15'(a + i), d});
      put(d, ok);
    end
    master.stop();
  endtask : ee_wr

  task automatic ee_rd(input logic [6:0] ad, input logic [14:0] a,
                       input int nb);
    logic [7:0] b;
    for (int i = 0; i < nb; i++)
      if (a + i <= EE_END)
        rq.push_back({1'b1, 15'(a + i)});
    open_tx(ad, 1'b0, 1'b1);
    put({1'b1, a[14:8]}, 1'b1);
    put(a[7:0], 1'b1);
    open_tx(ad, 1'b1, 1'b1);
    for (int i = 0; i < nb; i++)
    begin
      master.rd_byte(i < nb - 1, b);
      chk("rd_byte", (a + i <= EE_END) ? pat(15'(a + i)) : 8'hff, b);
    end
    master.stop();
  endtask : ee_rd

  // sink stalls at random, or fully while hold is set
  always @(posedge clk)
  begin
    wr_ready <= hold ? 1'b0 : 1'($random(seed));
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      if (wq.size() == 0)
        chk("wr_extra", 24'h0, 24'h1);
      else
        chk("wr_word", wq.pop_front(), wr_word);
    if (commit === 1'b1)
      commits++;
    busy_cnt <= (commit === 1'b1) ? BUSY : (busy_cnt != 0 ? busy_cnt - 1 : 0);
    run <= (scl_oe_n === 1'b0) ? run + 1 : 0;
    if (run > mx)
      mx <= run;
  end

  // memory side answers three cycles after each request
  always @(posedge clk)
  begin
    rd_valid <= rd_cnt == 1;
    rd_data <= (rd_cnt == 1) ? pat(rd_word.addr) : ~rd_data;
    if (rd_req === 1'b1)
    begin
      rd_cnt <= 3;
      if (rq.size() == 0)
        chk("rd_extra", 24'h0, 24'h1);
      else
        chk("rd_word", 24'(rq.pop_front()), 24'(rd_word));
    end
    else if (rd_cnt != 0)
      rd_cnt <= rd_cnt - 1;
  end

  initial
  begin
    repeat (80000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial
  begin
    clk = 0; rstn = 0; pin_rst = 0; a0 = 0; ext = 0; ext_n = 0; wd_en = 0;
    wblk = 0; hold = 0; wr_ready = 0; rd_valid = 0; rd_data = 8'h00;
    err_count = 0; samples_checked = 0; commits = 0; run = 0; mx = 0;
    busy_cnt = 0; rd_cnt = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int n = 0; n <= 6; n++)
    begin
      ext_n <= 3'(n);
      ext <= 6'($random(seed));
      a0 <= 1'($random(seed));
      @(posedge clk);
      mad = dev(dual_target_pkg::MP_FIXED, 3'(n));
      ead = dev(dual_target_pkg::EE_FIXED, 3'(n));
      open_tx(mad ^ 7'h01, 1'b0, 1'b0);
      master.stop();
      mp_write(mad, 2);
      c0 = 15'($random(seed)) & 15'h01de;
      ee_wr(ead, 15'(c0), 1);
      ee_rd(ead, 15'(c0), 2);
    end
    // earlier stretches are short, so the running maximum stays meaningful
    c0 = commits;
    ee_wr(ead, 15'h003e, 3);
    chk("commits", 24'h2, 24'(commits - c0));
    chk("stretch", 24'h1, 24'(mx > BUSY));
    ee_wr(ead, EE_END, 2);
    ee_rd(ead, EE_END, 2);
    // counter now sits one past the end: a read address is refused
    open_tx(ead, 1'b1, 1'b0);
    master.stop();
    wd_en <= 1'b1;
    wblk <= 1'b1;
    @(posedge clk);
    ee_wr(ead, 15'h0100, 1);
    wd_en <= 1'b0;
    @(posedge clk);
    ee_wr(ead, 15'h0102, 1);
    wblk <= 1'b0;
    hold <= 1'b1;
    fork
      begin
        repeat (1500) @(posedge clk);
        hold <= 1'b0;
      end
    join_none
    mp_write(mad, 4);
    open_tx(mad, 1'b0, 1'b1);
    put(8'h05, 1'b1);
    pin_rst <= 1'b1;
    @(posedge clk);
    pin_rst <= 1'b0;
    @(posedge clk);
    chk("oe_n", 24'h3, {22'h0, scl_oe_n, sda_oe_n});
    put(8'h33, 1'b0);
    master.stop();
    // pointer survives the pin reset; read it back through the register path
    rq.push_back({1'b0, 15'h0005});
    open_tx(mad, 1'b1, 1'b1);
    master.rd_byte(1'b0, rb);
    chk("mp_rd", pat(15'h0005), rb);
    master.stop();
    repeat (50) @(posedge clk);
    chk("left", 24'h0, 24'(wq.size() + rq.size()));
    close_out();
  end
endmodule : testbench
`default_nettype wire
